// File: design/rid_core.sv
// module: return decode, call linkage, trace flags and interrupt acceptance
// assumes: core pipeline supplies one-cycle instruction strobes and table data
`timescale 1ns/1ps
`default_nettype none
module rid_core
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // procedure exit and its frame link
  input  wire logic        ret_in,
  input  wire logic [3:0]  previous_frame_link_reg_in,
  // calls
  input  wire logic        call_local_in,
  input  wire logic        call_supv_in,
  input  wire logic        table_trace_ctl_in,
  input  wire logic        call_trace_mode_in,
  input  wire logic        prereturn_trace_mode_in,
  // branch with link
  input  wire logic        bal_in,
  input  wire logic        balx_in,
  input  wire logic [4:0]  balx_reg_sel_in,
  input  wire logic [31:0] bal_target_in,
  input  wire logic [31:0] next_ip_in,
  // interrupt sources
  input  wire logic [7:0]  ext_int_vec_in,
  input  wire logic        ext_int_req_in,
  input  wire logic        nmi_n_in,
  input  wire logic [7:0]  int_vec_in,
  input  wire logic        int_req_in,
  input  wire logic        int_ack_ready_in,
  input  wire logic [31:0] vector_data_in,
  input  wire logic        vector_data_valid_in,
  input  wire logic [4:0]  cur_pri_in,
  // outputs
  output logic [3:0]       new_rt_field_out,
  output logic             rt_write_out,
  output logic [2:0]       ret_action_out,
  output logic             ret_go_out,
  output logic             prereturn_trace_event_out,
  output logic             user_mode_out,
  output logic             trace_enable_bit_out,
  output logic             stack_user_out,
  output logic             stack_int_out,
  output logic             link_write_out,
  output logic [4:0]       link_reg_sel_out,
  output logic [31:0]      link_data_out,
  output logic             branch_out,
  output logic [31:0]      branch_target_out,
  output logic             alloc_frame_out,
  output logic             vec_fetch_out,
  output logic [7:0]       vec_fetch_num_out,
  output logic             int_call_out,
  output logic [31:0]      int_handler_out,
  output logic             save_state_out,
  output logic             restore_state_out,
  output logic             in_nmi_out,
  output logic [4:0]       exec_pri_out
);

  typedef enum logic [3:0]
  {
    RID_IDLE  = 4'h1,
    RID_FETCH = 4'h2,
    RID_CALL  = 4'h4,
    RID_RET   = 4'h8
  } rid_state_t;

  rid_state_t  state;
  rid_state_t  next_state;
  logic [255:0] pending;
  logic [7:0]  active_vec;
  logic        stack_int_saved;
  logic        nmi_s1;
  logic        nmi_s2;
  logic        nmi_s3;
  logic        nmi_edge;
  logic        nmi_level;
  logic        in_nmi;
  logic        preempt;
  logic [2:0]  decoded;
  logic        held_ret;
  logic [3:0]  held_rt;
  rid_arb_if   arb_bus ();

  rid_arbiter u_arb
  (
    .pending_in (pending),
    .arb        (arb_bus)
  );

  // non-maskable pin: three-stage sync, falling edge sets the NMI pending bit
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      nmi_s1 <= 1'b1;
      nmi_s2 <= 1'b1;
      nmi_s3 <= 1'b1;
    end
    else
    begin
      nmi_s1 <= nmi_n_in;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
    end
  end

  // pin level accepted only once stages two and three agree
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      nmi_level <= 1'b1;
    else if (nmi_s2 == nmi_s3)
      nmi_level <= nmi_s3;
  end
  assign nmi_edge = nmi_level & ~nmi_s2 & ~nmi_s3;

  always_comb
  begin
    if (held_rt[2:0] == rid_pkg::RT_LOCAL)
      decoded = rid_pkg::ACT_LOCAL;
    else if (held_rt[2:1] == rid_pkg::RT_SUPV)
      decoded = rid_pkg::ACT_SUPV;
    else if (held_rt[2:0] == rid_pkg::RT_FAULT)
      decoded = rid_pkg::ACT_FAULT;
    else if (held_rt[2:0] == rid_pkg::RT_INTR)
      decoded = rid_pkg::ACT_INTR;
    else
      decoded = rid_pkg::ACT_RSVD;
  end

  always_comb
  begin
    preempt = 1'b0;
    if (pending[rid_pkg::NMI_VECTOR] && !in_nmi)
      preempt = 1'b1;
    else if (arb_bus.cand_valid && !in_nmi && arb_bus.cand_pri != 5'h00)
    begin
      // priority 0 never preempts; 31 beats 31
      if (arb_bus.cand_pri > cur_pri_in)
        preempt = 1'b1;
      else if (arb_bus.cand_pri == rid_pkg::PRI_MAX && cur_pri_in == rid_pkg::PRI_MAX)
        preempt = 1'b1;
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      RID_IDLE:
      begin
        if (held_ret)
          next_state = RID_RET;
        else if (preempt && int_ack_ready_in)
          next_state = RID_FETCH;
      end
      RID_FETCH:
      begin
        if (vector_data_valid_in)
          next_state = RID_CALL;
      end
      RID_CALL:
        next_state = RID_IDLE;
      RID_RET:
        next_state = RID_IDLE;
      default:
        next_state = RID_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      state <= RID_IDLE;
    else
      state <= next_state;
  end

  // a return waits here while trace event and interrupt entry are sorted out
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      held_ret <= 1'b0;
      held_rt  <= 4'h0;
    end
    else if (ret_in)
    begin
      held_ret <= 1'b1;
      held_rt  <= previous_frame_link_reg_in;
    end
    else if (state == RID_IDLE && held_ret)
      held_ret <= 1'b0;
  end

  // pending set: new requests win over the clear
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pending <= '0;
    else
    begin
      if (state == RID_CALL)
        pending[active_vec] <= 1'b0;
      // vectors below 8 are dropped; ports
      if (ext_int_req_in && ext_int_vec_in[7:3] != 5'h00)
        pending[ext_int_vec_in] <= 1'b1;
      if (int_req_in && int_vec_in[7:3] != 5'h00)
        pending[int_vec_in] <= 1'b1;
      if (nmi_edge)
        pending[rid_pkg::NMI_VECTOR] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      active_vec        <= 8'h00;
      vec_fetch_out     <= 1'b0;
      vec_fetch_num_out <= 8'h00;
      int_call_out      <= 1'b0;
      int_handler_out   <= 32'h0000_0000;
      exec_pri_out      <= 5'h00;
    end
    else
    begin
      vec_fetch_out <= 1'b0;
      int_call_out  <= 1'b0;
      if (state == RID_IDLE && next_state == RID_FETCH)
      begin
        active_vec        <= pending[rid_pkg::NMI_VECTOR] ? rid_pkg::NMI_VECTOR
                                                          : arb_bus.cand_vector;
        vec_fetch_out     <= 1'b1;
        vec_fetch_num_out <= pending[rid_pkg::NMI_VECTOR] ? rid_pkg::NMI_VECTOR
                                                          : arb_bus.cand_vector;
      end
      if (state == RID_FETCH && vector_data_valid_in)
      begin
        int_call_out    <= 1'b1;
        int_handler_out <= {vector_data_in[31:2], 2'h0};
        exec_pri_out    <= active_vec[7:rid_pkg::PRI_SHIFT];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      save_state_out    <= 1'b0;
      restore_state_out <= 1'b0;
      stack_int_out     <= 1'b0;
      stack_int_saved   <= 1'b0;
      alloc_frame_out   <= 1'b0;
      in_nmi            <= 1'b0;
    end
    else
    begin
      save_state_out    <= 1'b0;
      restore_state_out <= 1'b0;
      alloc_frame_out   <= call_local_in | call_supv_in;
      if (state == RID_FETCH && vector_data_valid_in)
      begin
        save_state_out  <= 1'b1;
        alloc_frame_out <= 1'b1;
        stack_int_saved <= stack_int_out;
        stack_int_out   <= 1'b1;
        if (active_vec == rid_pkg::NMI_VECTOR)
          in_nmi <= 1'b1;
      end
      else if (state == RID_RET && decoded == rid_pkg::ACT_INTR
               && !(held_rt[rid_pkg::RT_P_BIT] && prereturn_trace_mode_in))
      begin
        restore_state_out <= 1'b1;
        stack_int_out     <= stack_int_saved;
        in_nmi            <= 1'b0;
      end
    end
  end
  assign in_nmi_out = in_nmi;

  // mode, trace enable, user stack
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      user_mode_out        <= 1'b0;
      trace_enable_bit_out <= 1'b0;
      stack_user_out       <= 1'b0;
    end
    else if (state == RID_FETCH && vector_data_valid_in)
      user_mode_out <= 1'b0;
    else if (call_supv_in && user_mode_out)
    begin
      trace_enable_bit_out <= table_trace_ctl_in;
      user_mode_out        <= 1'b0;
      stack_user_out       <= 1'b0;
    end
    else if (state == RID_RET && decoded == rid_pkg::ACT_SUPV
             && !(held_rt[rid_pkg::RT_P_BIT] && prereturn_trace_mode_in))
    begin
      // back to user with saved t
      user_mode_out        <= 1'b1;
      stack_user_out       <= 1'b1;
      trace_enable_bit_out <= held_rt[rid_pkg::RT_T_BIT];
    end
  end

  // return-type field written at call time
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      new_rt_field_out <= 4'h0;
      rt_write_out     <= 1'b0;
    end
    else
    begin
      rt_write_out <= 1'b0;
      if (state == RID_FETCH && vector_data_valid_in)
      begin
        rt_write_out     <= 1'b1;
        new_rt_field_out <= {call_trace_mode_in, rid_pkg::RT_INTR};
      end
      else if (call_supv_in && user_mode_out)
      begin
        rt_write_out     <= 1'b1;
        // save trace enable in bit 0
        new_rt_field_out <= {call_trace_mode_in, rid_pkg::RT_SUPV, trace_enable_bit_out};
      end
      else if (call_local_in || call_supv_in)
      begin
        rt_write_out     <= 1'b1;
        new_rt_field_out <= {call_trace_mode_in, rid_pkg::RT_LOCAL};
      end
    end
  end

  // return action or prereturn trace event
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ret_action_out            <= rid_pkg::ACT_LOCAL;
      ret_go_out                <= 1'b0;
      prereturn_trace_event_out <= 1'b0;
    end
    else
    begin
      ret_go_out                <= 1'b0;
      prereturn_trace_event_out <= 1'b0;
      if (state == RID_RET)
      begin
        // trace event instead of any return work
        if (held_rt[rid_pkg::RT_P_BIT] && prereturn_trace_mode_in)
          prereturn_trace_event_out <= 1'b1;
        else
        begin
          ret_go_out     <= 1'b1;
          ret_action_out <= decoded;
        end
      end
    end
  end

  // link register; no frame allocated here
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      link_write_out    <= 1'b0;
      link_reg_sel_out  <= 5'h00;
      link_data_out     <= 32'h0000_0000;
      branch_out        <= 1'b0;
      branch_target_out <= 32'h0000_0000;
    end
    else
    begin
      link_write_out <= bal_in | balx_in;
      branch_out     <= bal_in | balx_in;
      if (bal_in || balx_in)
      begin
        link_reg_sel_out  <= balx_in ? balx_reg_sel_in : rid_pkg::LINK_GLOBAL_SEL;
        link_data_out     <= next_ip_in;
        branch_target_out <= bal_target_in;
      end
    end
  end

endmodule // rid_core
`default_nettype wire

// File: design/rid_pkg.sv
// package: constants for the return and interrupt dispatch block
// assumes: nothing beyond a SystemVerilog compiler
package rid_pkg;
  // return-type field bits
  localparam int RT_W        = 4;
  localparam int RT_P_BIT    = 3;
  localparam int RT_T_BIT    = 0;
  localparam logic [2:0] RT_LOCAL = 3'h0;
  localparam logic [2:0] RT_FAULT = 3'h1;
  localparam logic [1:0] RT_SUPV  = 2'h1;
  localparam logic [2:0] RT_INTR  = 3'h7;
  // return action codes
  localparam logic [2:0] ACT_LOCAL = 3'h0;
  localparam logic [2:0] ACT_SUPV  = 3'h1;
  localparam logic [2:0] ACT_FAULT = 3'h2;
  localparam logic [2:0] ACT_INTR  = 3'h3;
  localparam logic [2:0] ACT_RSVD  = 3'h4;
  // vectors and priorities
  localparam int VEC_W       = 8;
  localparam int PRI_W       = 5;
  localparam int PRI_SHIFT   = 3;
  localparam logic [4:0] PRI_MAX = 5'h1f;
  localparam logic [7:0] NMI_VECTOR = 8'hf8;
  localparam int ADDR_W      = 32;
  localparam int REG_SEL_W   = 5;
  localparam logic [4:0] LINK_GLOBAL_SEL = 5'h1e;
endpackage

// File: design/rid_arb_if.sv
// interface: carries the winning pending request between arbiter and core
// assumes: both ends share sys_clk_in
`timescale 1ns/1ps
`default_nettype none
interface rid_arb_if;
  logic       cand_valid;
  logic [7:0] cand_vector;
  logic [4:0] cand_pri;
  modport arb  (output cand_valid, output cand_vector, output cand_pri);
  modport core (input cand_valid, input cand_vector, input cand_pri);
endinterface
`default_nettype wire

// File: design/rid_arbiter.sv
// module: picks the highest pending vector from a 256-bit pending set
// assumes: pending bits come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module rid_arbiter
(
  input  wire logic [255:0] pending_in,
  rid_arb_if.arb            arb
);
  logic [7:0] best;
  logic       found;
  // highest vector wins; vector/8 is monotonic so highest level wins too
  always_comb
  begin
    best  = 8'h00;
    found = 1'b0;
    for (int i = 8; i < 256; i++)
    begin
      if (pending_in[i])
      begin
        best  = 8'(i);
        found = 1'b1;
      end
    end
  end
  assign arb.cand_valid  = found;
  assign arb.cand_vector = best;
  assign arb.cand_pri    = best[7:3];
endmodule // rid_arbiter
`default_nettype wire

// File: verification/rid_core_props.sv
// checker: port timing of rid_core
// assumes: bound into rid_core by port name, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rid_core_props
(
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  input wire logic        ret_in,
  input wire logic [3:0]  previous_frame_link_reg_in,
  input wire logic        call_local_in,
  input wire logic        call_supv_in,
  input wire logic        table_trace_ctl_in,
  input wire logic        call_trace_mode_in,
  input wire logic        prereturn_trace_mode_in,
  input wire logic        bal_in,
  input wire logic [31:0] next_ip_in,
  input wire logic [3:0]  new_rt_field_out,
  input wire logic        rt_write_out,
  input wire logic [2:0]  ret_action_out,
  input wire logic        ret_go_out,
  input wire logic        prereturn_trace_event_out,
  input wire logic        user_mode_out,
  input wire logic        trace_enable_bit_out,
  input wire logic        stack_int_out,
  input wire logic        link_write_out,
  input wire logic [4:0]  link_reg_sel_out,
  input wire logic [31:0] link_data_out,
  input wire logic        branch_out,
  input wire logic        alloc_frame_out,
  input wire logic        vec_fetch_out,
  input wire logic [7:0]  vec_fetch_num_out,
  input wire logic        int_call_out,
  input wire logic        save_state_out,
  input wire logic        restore_state_out,
  input wire logic        in_nmi_out,
  input wire logic [4:0]  exec_pri_out
);
  logic [3:0] pfl;
  assign pfl = previous_frame_link_reg_in;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  property p_ret_local;
    ret_in && pfl == 4'h0 |-> ##3 ret_go_out && ret_action_out == rid_pkg::ACT_LOCAL
      && user_mode_out == $past(user_mode_out, 3);
  endproperty
  a_ret_local: assert property (p_ret_local) else $error("local return wrong");
  property p_ret_supv;
    ret_in && pfl[3:1] == 3'h1 |-> ##3 ret_go_out && ret_action_out == rid_pkg::ACT_SUPV
      && user_mode_out && trace_enable_bit_out == $past(pfl[0], 3);
  endproperty
  a_ret_supv: assert property (p_ret_supv) else $error("supervisor return wrong");
  property p_pretrace;
    ret_in && pfl[3] && prereturn_trace_mode_in |-> ##3 prereturn_trace_event_out && !ret_go_out;
  endproperty
  a_pretrace: assert property (p_pretrace) else $error("prereturn trace missed");
  property p_call_flag;
    call_local_in || call_supv_in |=> rt_write_out && alloc_frame_out
      && new_rt_field_out[3] == $past(call_trace_mode_in);
  endproperty
  a_call_flag: assert property (p_call_flag) else $error("call trace flag wrong");
  property p_supv_call;
    call_supv_in && user_mode_out |=> new_rt_field_out[2:0] == {2'b01, $past(trace_enable_bit_out)}
      && !user_mode_out && trace_enable_bit_out == $past(table_trace_ctl_in);
  endproperty
  a_supv_call: assert property (p_supv_call) else $error("supervisor call wrong");
  property p_bal;
    bal_in |=> link_write_out && branch_out && !alloc_frame_out
      && link_reg_sel_out == rid_pkg::LINK_GLOBAL_SEL && link_data_out == $past(next_ip_in);
  endproperty
  a_bal: assert property (p_bal) else $error("branch link wrong");
  property p_int_call;
    int_call_out |-> save_state_out && alloc_frame_out && stack_int_out && !user_mode_out
      && new_rt_field_out[2:0] == rid_pkg::RT_INTR && exec_pri_out == vec_fetch_num_out[7:3];
  endproperty
  a_int_call: assert property (p_int_call) else $error("interrupt call wrong");
  property p_fetch;
    vec_fetch_out |-> vec_fetch_num_out[7:3] != 5'h0 && !$past(in_nmi_out);
  endproperty
  a_fetch: assert property (p_fetch) else $error("bad vector fetch");
  property p_rt_codes;
    rt_write_out |-> new_rt_field_out[2:0] == rid_pkg::RT_LOCAL
      || new_rt_field_out[2:1] == rid_pkg::RT_SUPV || new_rt_field_out[2:0] == rid_pkg::RT_INTR;
  endproperty
  a_rt_codes: assert property (p_rt_codes) else $error("reserved return code written");
  property p_int_ret;
    ret_in && pfl == 4'h7 |-> ##3 ret_go_out && restore_state_out && !in_nmi_out
      && ret_action_out == rid_pkg::ACT_INTR;
  endproperty
  a_int_ret: assert property (p_int_ret) else $error("interrupt return wrong");
endmodule // rid_core_props
bind rid_core rid_core_props u_props (.*);
`default_nettype wire

// File: verification/rid_vec_table.sv
// model: vector table reads, answers fast and slow in turn
// assumes: fetch strobe and number from rid_core on the same clock
`timescale 1ns/1ps
`default_nettype none
module rid_vec_table
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        vec_fetch_out,
  input  wire logic [7:0]  vec_fetch_num_out,
  output logic [31:0]      vector_data_in,
  output logic             vector_data_valid_in
);
  logic [3:0] wait_cnt;
  logic       busy;
  logic       slow;
  logic [7:0] num;
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      busy <= 1'b0;
      slow <= 1'b0;
      num <= 8'h0;
      wait_cnt <= 4'h0;
      vector_data_valid_in <= 1'b0;
      vector_data_in <= 32'h0;
    end
    else
    begin
      vector_data_valid_in <= 1'b0;
      vector_data_in <= ~vector_data_in;
      if (vec_fetch_out)
      begin
        busy <= 1'b1;
        num <= vec_fetch_num_out;
        wait_cnt <= slow ? 4'h5 : 4'h0;
        slow <= ~slow;
      end
      else if (busy && wait_cnt != 4'h0)
        wait_cnt <= wait_cnt - 4'h1;
      else if (busy)
      begin
        busy <= 1'b0;
        vector_data_valid_in <= 1'b1;
        vector_data_in <= {8'h40, num, 16'h0};
      end
    end
endmodule // rid_vec_table
`default_nettype wire

// File: verification/rid_core_tb.sv
// testbench: returns, calls, links and interrupt acceptance of rid_core
// assumes: rid_vec_table answers the vector fetches
`timescale 1ns/1ps
`default_nettype none
module rid_core_tb;
  logic sys_clk_in = 1'b0, reset_n_in = 1'b0, ret_in = 1'b0, nmi_n_in = 1'b1;
  logic call_local_in = 1'b0, call_supv_in = 1'b0, table_trace_ctl_in = 1'b0;
  logic call_trace_mode_in = 1'b0, prereturn_trace_mode_in = 1'b0, bal_in = 1'b0;
  logic balx_in = 1'b0, ext_int_req_in = 1'b0, int_req_in = 1'b0, int_ack_ready_in = 1'b1;
  logic [3:0] previous_frame_link_reg_in = 4'h0;
  logic [4:0] balx_reg_sel_in = 5'h0, cur_pri_in = 5'h0;
  logic [7:0] ext_int_vec_in = 8'h0, int_vec_in = 8'h0;
  logic [31:0] bal_target_in = 32'h0, next_ip_in = 32'h0;
  wire logic [31:0] vector_data_in;
  wire logic vector_data_valid_in;
  logic [3:0] new_rt_field_out;
  logic [2:0] ret_action_out;
  logic [4:0] link_reg_sel_out, exec_pri_out;
  logic [7:0] vec_fetch_num_out;
  logic [31:0] link_data_out, branch_target_out, int_handler_out;
  logic rt_write_out, ret_go_out, prereturn_trace_event_out, user_mode_out, stack_int_out;
  logic trace_enable_bit_out, stack_user_out, link_write_out, branch_out, alloc_frame_out;
  logic vec_fetch_out, int_call_out, save_state_out, restore_state_out, in_nmi_out;
  int   n_fail = 0;
  int   checks = 0;
  int   cycles = 0;
  rid_core uut (.*);
  rid_vec_table u_table (.*);
  always #5 sys_clk_in = ~sys_clk_in;
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      finish_test;
    end
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [2:0] exp_act(input logic [2:0] c);
    case (c)
      3'h0: return rid_pkg::ACT_LOCAL;
      3'h1: return rid_pkg::ACT_FAULT;
      3'h2, 3'h3: return rid_pkg::ACT_SUPV;
      3'h7: return rid_pkg::ACT_INTR;
      default: return rid_pkg::ACT_RSVD;
    endcase
  endfunction
  // ret with mode check when m is set; expected mode u and trace bit t
  task automatic do_ret(input logic [3:0] f, input logic m, input logic u, input logic t);
    logic ev;
    ev = f[3] & prereturn_trace_mode_in;
    @(negedge sys_clk_in);
    previous_frame_link_reg_in = f;
    ret_in = 1'b1;
    @(negedge sys_clk_in);
    ret_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    chk({ret_go_out, prereturn_trace_event_out}, {!ev, ev}, "ret pulse");
    if (!ev)
      chk(ret_action_out, exp_act(f[2:0]), "action");
    if (!ev && m)
      chk({user_mode_out, stack_user_out, trace_enable_bit_out}, {u, u, t}, "mode");
  endtask
  task automatic do_call(input logic supv, input logic [3:0] f, input logic t);
    @(negedge sys_clk_in);
    call_supv_in = supv;
    call_local_in = !supv;
    @(negedge sys_clk_in);
    call_supv_in = 1'b0;
    call_local_in = 1'b0;
    chk({rt_write_out, alloc_frame_out, new_rt_field_out}, {2'b11, f}, "call");
    chk({user_mode_out, stack_user_out, trace_enable_bit_out}, {2'b00, t}, "call mode");
  endtask
  task automatic do_bal(input logic x, input logic [4:0] sel);
    @(negedge sys_clk_in);
    bal_target_in = 32'h0000_1a2c;
    next_ip_in = {27'h0, sel} + 32'h0000_0740;
    balx_reg_sel_in = sel;
    bal_in = !x;
    balx_in = x;
    @(negedge sys_clk_in);
    bal_in = 1'b0;
    balx_in = 1'b0;
    chk({link_write_out, branch_out, alloc_frame_out, link_reg_sel_out},
        {3'h6, x ? sel : rid_pkg::LINK_GLOBAL_SEL}, "link");
    chk({link_data_out, 8'h0}, {{27'h0, sel} + 32'h0000_0740, 8'h0}, "link data");
    chk(branch_target_out, 32'h0000_1a2c, "target");
  endtask
  task automatic req(input logic [7:0] v, input logic ext);
    @(negedge sys_clk_in);
    ext_int_vec_in = v;
    int_vec_in = v;
    ext_int_req_in = ext;
    int_req_in = !ext;
    @(negedge sys_clk_in);
    ext_int_req_in = 1'b0;
    int_req_in = 1'b0;
  endtask
  task automatic none(input int n);
    repeat (n)
    begin
      @(negedge sys_clk_in);
      chk(vec_fetch_out, 1'b0, "no fetch");
    end
  endtask
  task automatic take_int(input logic [7:0] v);
    int n;
    n = 0;
    while (vec_fetch_out !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    chk({vec_fetch_out, vec_fetch_num_out}, {1'b1, v}, "fetch");
    n = 0;
    while (int_call_out !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    chk({int_call_out, int_handler_out}, {1'b1, 8'h40, v, 16'h0}, "handler");
    chk({save_state_out, stack_int_out, user_mode_out, exec_pri_out}, {3'h6, v[7:3]}, "entry");
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    do_ret(4'h0, 1'b1, 1'b0, 1'b0);
    do_ret(4'h3, 1'b1, 1'b1, 1'b1);
    do_ret(4'h8, 1'b1, 1'b1, 1'b1);
    prereturn_trace_mode_in = 1'b1;
    do_ret(4'ha, 1'b0, 1'b0, 1'b0);
    prereturn_trace_mode_in = 1'b0;
    call_trace_mode_in = 1'b1;
    do_call(1'b1, 4'hb, 1'b0);
    do_call(1'b1, 4'h8, 1'b0);
    do_ret(4'h2, 1'b1, 1'b1, 1'b0);
    table_trace_ctl_in = 1'b1;
    call_trace_mode_in = 1'b0;
    do_call(1'b1, 4'h2, 1'b1);
    do_call(1'b0, 4'h0, 1'b1);
    do_bal(1'b0, 5'h03);
    do_bal(1'b1, 5'h07);
    for (int i = 0; i < 6; i++)
      do_ret({1'b0, 3'h1 + 3'(i)}, 1'b0, 1'b0, 1'b0);
    req(8'h05, 1'b1);
    none(20);
    int_ack_ready_in = 1'b0;
    req(8'h50, 1'b1);
    req(8'h57, 1'b0);
    req(8'h3f, 1'b1);
    int_ack_ready_in = 1'b1;
    take_int(8'h57);
    int_ack_ready_in = 1'b0;
    do_ret(4'h7, 1'b0, 1'b0, 1'b0);
    chk({restore_state_out, stack_int_out, in_nmi_out}, 3'h4, "int return");
    int_ack_ready_in = 1'b1;
    take_int(8'h50);
    take_int(8'h3f);
    cur_pri_in = 5'h05;
    req(8'h2c, 1'b0);
    none(20);
    cur_pri_in = 5'h04;
    take_int(8'h2c);
    cur_pri_in = 5'h1f;
    req(8'hfc, 1'b1);
    take_int(8'hfc);
    nmi_n_in = 1'b0;
    take_int(rid_pkg::NMI_VECTOR);
    nmi_n_in = 1'b1;
    chk(in_nmi_out, 1'b1, "nmi");
    req(8'hff, 1'b1);
    none(20);
    do_ret(4'h7, 1'b0, 1'b0, 1'b0);
    chk({restore_state_out, stack_int_out, in_nmi_out}, 3'h6, "nmi return");
    take_int(8'hff);
    finish_test;
  end
endmodule // rid_core_tb
`default_nettype wire
